// File: verilog/aux_port_pkg.sv
// shared constants and carrier types for the six-bit auxiliary port
// assumes a single 125 MHz clock domain and no register bus
`default_nettype none
package aux_port_pkg;
	localparam int AUX_WIDTH = 6;
	localparam int DIR_FIELD_WIDTH = 8;
	// bits 0..2 come up as outputs, 3..5 as inputs
	localparam logic [5:0] DIR_RESET = 6'h07;
	localparam logic [5:0] LEVEL_RESET = 6'h00;
	localparam int SHARED_BITS = 3;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [3:0] {
		CMD_NONE  = 4'h1,
		CMD_HIGH  = 4'h2,
		CMD_LOW   = 4'h4,
		CMD_DIRS  = 4'h8
	} cmd_t;

	typedef struct packed {
		cmd_t                        op;
		logic [2:0]                  bit_sel;
		logic [DIR_FIELD_WIDTH-1:0]  dirs;
	} aux_cmd_t;

	typedef struct packed {
		logic [AUX_WIDTH-1:0] out;
		logic [AUX_WIDTH-1:0] oe;
	} pad_drive_t;
endpackage
`default_nettype wire

// File: verilog/aux_pin_sync.sv
// one pin input synchroniser: three flops, change accepted on agreement
// assumes the pin is asynchronous to CLK
`default_nettype none
module aux_pin_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (s2_q == s3_q) begin
			level <= s3_q;
		end
	end
endmodule
`default_nettype wire

// File: verilog/aux_port.sv
// six-bit auxiliary general-purpose port with per-bit direction
// assumes the core issues one-cycle command strobes on CLK; no bus
// What this block does
// R1 - six single-bit pins, numbered zero to five
// R2 - direction bit: zero input, one output
// R3 - high/low command forces output and level
// R4 - direction field write sets all six
// R5 - bits zero to two output after reset
// R6 - input levels sampled and tested per bit
// R7 - bits three to five hold static levels
// R8 - inputs read only as static levels
// R9 - bits zero to two share general outputs
// R10 - board adds 1k series resistor on inputs
// R11 - top two direction field bits ignored
`default_nettype none
module aux_port
	import aux_port_pkg::*;
#(
	parameter int WIDTH = AUX_WIDTH
) (
	input  wire logic             CLK,
	input  wire logic             RESET_N,
	input  wire logic             CMD_VALID,
	input  wire aux_cmd_t         CMD,
	input  wire logic [2:0]       TEST_SEL,
	input  wire logic [2:0]       GEN_OUT,
	input  wire logic [2:0]       GEN_OUT_USE,
	input  wire logic [WIDTH-1:0] PIN_IN,
	output logic      [WIDTH-1:0] PIN_OUT,
	output logic      [WIDTH-1:0] PIN_OE,
	output logic      [WIDTH-1:0] DIRS,
	output logic      [WIDTH-1:0] PORT_LEVELS,
	output logic                  TEST_BIT
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// direction and level state
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] lvl_q;
	logic             sel_ok;

	// selects 6 and 7 name no pin and are dropped
	assign sel_ok = (CMD.bit_sel < 3'(WIDTH)); // R1

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= DIR_RESET; // R5
		end else if (CMD_VALID) begin
			case (CMD.op)
				CMD_HIGH, CMD_LOW: begin
					if (sel_ok) begin
						dir_q[CMD.bit_sel] <= 1'b1; // R3
					end
				end
				CMD_DIRS: begin
					// upper two field bits have no pin
					dir_q <= CMD.dirs[WIDTH-1:0]; // R4 R11 R2
				end
				default: begin
					dir_q <= dir_q;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q <= LEVEL_RESET;
		end else if (CMD_VALID && sel_ok) begin
			case (CMD.op)
				CMD_HIGH: begin
					lvl_q[CMD.bit_sel] <= 1'b1; // R3
				end
				CMD_LOW: begin
					lvl_q[CMD.bit_sel] <= 1'b0; // R3
				end
				default: begin
					lvl_q <= lvl_q;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pad drive
	// ----------------------------------------------------------------
	// shared pins set as outputs follow the general output path when it claims them,
	// so timed functions reach only bits 0..2; bits 3..5 stay static
	pad_drive_t drv_d;

	always_comb begin
		drv_d.oe  = dir_q; // R2
		drv_d.out = lvl_q; // R7
		for (int i = 0; i < SHARED_BITS; i++) begin
			if (GEN_OUT_USE[i] && dir_q[i]) begin
				drv_d.out[i] = GEN_OUT[i]; // R9
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PIN_OUT <= LEVEL_RESET;
			PIN_OE  <= DIR_RESET;
			DIRS    <= DIR_RESET;
		end else begin
			PIN_OUT <= drv_d.out;
			PIN_OE  <= drv_d.oe;
			DIRS    <= dir_q;
		end
	end

	// ----------------------------------------------------------------
	// input sampling
	// ----------------------------------------------------------------
	// only synchronised static levels leave this block; no edge or
	// width measurement is offered on these pins
	logic [WIDTH-1:0] pin_lvl;

	for (genvar g = 0; g < WIDTH; g++) begin : g_sync
		aux_pin_sync u_sync (
			.clk   (CLK),
			.rst_n (rst_n),
			.pin   (PIN_IN[g]),
			.level (pin_lvl[g])
		);
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PORT_LEVELS <= LEVEL_RESET;
			TEST_BIT    <= 1'b0;
		end else begin
			PORT_LEVELS <= pin_lvl & ~dir_q; // R8
			TEST_BIT    <= (TEST_SEL < 3'(WIDTH)) && !dir_q[TEST_SEL]
				&& pin_lvl[TEST_SEL]; // R6
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_high_cmd_out: assert property (@(posedge CLK) disable iff (!rst_n) // R3
		CMD_VALID && CMD.op == CMD_HIGH && sel_ok
		|=> dir_q[$past(CMD.bit_sel)] && lvl_q[$past(CMD.bit_sel)])
		else $error("high command did not drive pin high");
	a_low_cmd_out: assert property (@(posedge CLK) disable iff (!rst_n) // R3
		CMD_VALID && CMD.op == CMD_LOW && sel_ok
		|=> dir_q[$past(CMD.bit_sel)] && !lvl_q[$past(CMD.bit_sel)])
		else $error("low command did not drive pin low");
	a_dirs_write: assert property (@(posedge CLK) disable iff (!rst_n) // R4
		CMD_VALID && CMD.op == CMD_DIRS |=> ##1 DIRS == $past(CMD.dirs[5:0], 2))
		else $error("direction field not applied");
	a_oe_follows_dir: assert property (@(posedge CLK) disable iff (!rst_n) // R2
		##1 PIN_OE == $past(dir_q))
		else $error("output enable does not track direction");
	a_reset_dirs: assert property (@(posedge CLK) // R5
		$rose(rst_n) |-> dir_q == 6'h07)
		else $error("reset directions wrong");
	a_static_upper: assert property (@(posedge CLK) disable iff (!rst_n) // R7
		##1 PIN_OUT[5:3] == $past(lvl_q[5:3]))
		else $error("upper bits not static levels");
	a_input_only_lvl: assert property (@(posedge CLK) disable iff (!rst_n) // R8
		##1 (PORT_LEVELS & $past(dir_q)) == 6'h00)
		else $error("output pin reported as input");
	a_test_output: assert property (@(posedge CLK) disable iff (!rst_n) // R6
		dir_q[TEST_SEL] && $stable(dir_q) |=> !TEST_BIT)
		else $error("test bit set on an output pin");
endmodule
`default_nettype wire

// File: sim/aux_loads.sv
// far-side model: one switch on each pin, seen when the port does not drive it
// assumes a series resistor, so a driven pin shows the port's level
`default_nettype none
module aux_loads (
	input  wire logic [5:0] oe,
	input  wire logic [5:0] drv,
	input  wire logic [5:0] sw,
	output logic      [5:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// pin level
	// ------------------------------------------------
	assign pin = (oe & drv) | (~oe & sw);
endmodule
`default_nettype wire

// File: sim/aux_port_test.sv
// self-checking bench for the auxiliary port, one task a scenario
// assumes the switch model stands on the pads
`default_nettype none
module aux_port_test;
	import aux_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// stimulus and checks
	// ------------------------------------------------
	logic       CLK = 0;
	logic       RESET_N = 0;
	logic       CMD_VALID = 0;
	aux_cmd_t   CMD = '{CMD_NONE, 3'h0, 8'h00};
	logic [2:0] TEST_SEL = 0;
	logic [2:0] GEN_OUT = 0;
	logic [2:0] GEN_OUT_USE = 0;
	logic [5:0] sw = 0;
	logic [5:0] PIN_IN, PIN_OUT, PIN_OE, DIRS, PORT_LEVELS;
	logic       TEST_BIT;
	int         error_cnt = 0;
	int         n_tests = 0;
	always #4 CLK = ~CLK;
	aux_loads LD (.oe(PIN_OE), .drv(PIN_OUT), .sw(sw), .pin(PIN_IN));
	aux_port DUT (.CLK(CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID),
		.CMD(CMD), .TEST_SEL(TEST_SEL), .GEN_OUT(GEN_OUT),
		.GEN_OUT_USE(GEN_OUT_USE), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
		.PIN_OE(PIN_OE), .DIRS(DIRS), .PORT_LEVELS(PORT_LEVELS),
		.TEST_BIT(TEST_BIT));
	task chk(string nm, logic [5:0] e, logic [5:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	// one-cycle strobe, then wait past the two-edge answer
	task send(cmd_t op, logic [2:0] b, logic [7:0] d);
		@(posedge CLK);
		CMD <= '{op, b, d};
		CMD_VALID <= 1;
		@(posedge CLK);
		CMD_VALID <= 0;
		CMD <= '{CMD_NONE, 3'h0, 8'h00};
		repeat (3) @(posedge CLK);
		#1;
	endtask
	task t_reset;
		chk("dirs", 6'h07, DIRS);
		chk("oe", 6'h07, PIN_OE);
	endtask
	task t_hilo;
		send(CMD_HIGH, 3'h4, 8'h00);
		chk("dirs", 6'h17, DIRS);
		chk("out", 6'h10, PIN_OUT & 6'h10);
		send(CMD_LOW, 3'h4, 8'h00);
		chk("out", 6'h00, PIN_OUT & 6'h10);
		send(CMD_HIGH, 3'h6, 8'h00);
		chk("dirs", 6'h17, DIRS);
	endtask
	task t_dirs;
		send(CMD_DIRS, 3'h0, 8'hFF);
		chk("dirs", 6'h3F, DIRS);
		send(CMD_DIRS, 3'h0, 8'hC0);
		chk("oe", 6'h00, PIN_OE);
	endtask
	task t_in;
		sw <= 6'h2A;
		repeat (8) @(posedge CLK);
		#1;
		chk("levels", 6'h2A, PORT_LEVELS);
		for (int i = 0; i < 6; i++) begin
			TEST_SEL <= i[2:0];
			repeat (3) @(posedge CLK);
			#1;
			chk("test", {5'h0, sw[i]}, {5'h0, TEST_BIT});
		end
		send(CMD_DIRS, 3'h0, 8'h38);
		repeat (6) @(posedge CLK);
		#1;
		chk("levels", 6'h02, PORT_LEVELS);
	endtask
	task t_share;
		send(CMD_DIRS, 3'h0, 8'h07);
		GEN_OUT_USE <= 3'h7;
		GEN_OUT <= 3'h5;
		repeat (3) @(posedge CLK);
		#1;
		chk("gen", 6'h05, {3'h0, PIN_OUT[2:0]});
		GEN_OUT_USE <= 3'h0;
		repeat (3) @(posedge CLK);
		#1;
		chk("gen", 6'h00, {3'h0, PIN_OUT[2:0]});
	endtask
	task conclude;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge CLK);
		RESET_N <= 1;
		repeat (3) @(posedge CLK);
		#1;
		t_reset();
		t_hilo();
		t_dirs();
		t_in();
		t_share();
		conclude();
	end
endmodule
`default_nettype wire
